// ### rtl/serial_link_bist.sv
// Notes on behaviour
// - test enable from back channel wakes the serializer from low power
// - in test, video inputs ignored; all-zeros words sent to scrambler
// - test clocked by pixel clock or internal oscillator, chosen by far end
// - back channel crc checked only while link detect is set
// - functional crc errors count in 8 bits, cleared on test entry
// - test crc count active in test only, kept until cleared or re-entry
// - enable low returns the link to normal video
`timescale 1ns/10ps
`default_nettype none
module serial_link_bist #(
   parameter int CNT_W = 8
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       pix_en,
   input  wire link_bist_pkg::video_s      video_in,
   input  wire link_bist_pkg::back_chan_s  back_chan,
   input  wire logic [7:0]                 addr,
   input  wire logic [31:0]                wr_data,
   input  wire logic                       wr_stb,
   input  wire logic                       rd_stb,
   output logic [31:0]                     rd_data,
   output link_bist_pkg::video_s           tx_word,
   output logic                            tx_valid,
   output logic                            power_on,
   output logic                            test_active,
   output logic                            irq
);

   localparam logic [17:0] ACC_STEP = 18'(link_bist_pkg::OSC_FREQ_KHZ);
   localparam logic [17:0] ACC_WRAP = 18'(link_bist_pkg::MCLK_FREQ_KHZ);

   link_bist_pkg::mode_e mode;
   link_bist_pkg::mode_e next_mode;
   logic [17:0]          osc_acc;
   logic [17:0]          next_osc_acc;
   logic                 osc_tick;
   logic                 next_osc_tick;
   logic                 word_tick;
   logic                 enter;
   logic                 leave;
   logic [31:0]          ctrl;
   logic [31:0]          next_ctrl;
   logic [CNT_W-1:0]     crc_func;
   logic [CNT_W-1:0]     next_crc_func;
   logic [CNT_W-1:0]     crc_test;
   logic [CNT_W-1:0]     next_crc_test;
   logic [link_bist_pkg::EV_W-1:0] int_stat;
   logic [link_bist_pkg::EV_W-1:0] next_int_stat;
   logic [link_bist_pkg::EV_W-1:0] int_mask;
   logic [link_bist_pkg::EV_W-1:0] next_int_mask;
   logic [link_bist_pkg::EV_W-1:0] events;
   link_bist_pkg::video_s next_tx_word;
   logic                 next_tx_valid;
   logic                 next_power_on;
   logic                 next_irq;
   logic [31:0]          next_rd_data;
   logic                 crc_hit;
   logic                 clr_test_wr;

   // saturating increment of an error count
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
      bump = (v == CNT_W'(link_bist_pkg::CNT_MAX)) ? v : v + CNT_W'(1);
   endfunction

   // register write decode
   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
      wr_hit = wr_stb && (a == off);
   endfunction

   assign enter       = back_chan.test_enable && (mode == link_bist_pkg::MODE_NORMAL);
   assign leave       = !back_chan.test_enable && (mode == link_bist_pkg::MODE_TEST);
   assign crc_hit     = back_chan.crc_error && back_chan.link_detect;
   assign clr_test_wr = wr_hit(addr, link_bist_pkg::ADDR_CTRL)
                        && wr_data[link_bist_pkg::CTRL_CLR_TEST];

   // word pacing: pixel tick normally, oscillator in test when far end picks it
   assign word_tick = (mode == link_bist_pkg::MODE_TEST && back_chan.clk_sel_osc)
                      ? osc_tick : pix_en;

   // oscillator rate enable from a phase accumulator
   always_comb
   begin
      next_osc_acc  = osc_acc + ACC_STEP;
      next_osc_tick = 1'b0;
      if (next_osc_acc >= ACC_WRAP)
      begin
         next_osc_acc  = next_osc_acc - ACC_WRAP;
         next_osc_tick = 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         osc_acc  <= '0;
         osc_tick <= 1'b0;
      end
      else
      begin
         osc_acc  <= next_osc_acc;
         osc_tick <= next_osc_tick;
      end
   end

   // mode, wake and outgoing word
   always_comb
   begin
      next_mode     = back_chan.test_enable ? link_bist_pkg::MODE_TEST
                                            : link_bist_pkg::MODE_NORMAL;
      next_power_on = !ctrl[link_bist_pkg::CTRL_SLEEP] || back_chan.test_enable;
      next_tx_word  = tx_word;
      next_tx_valid = word_tick;
      if (word_tick)
      begin
         unique case (mode)
            link_bist_pkg::MODE_TEST:   next_tx_word = '0;
            link_bist_pkg::MODE_NORMAL: next_tx_word = video_in;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mode        <= link_bist_pkg::MODE_NORMAL;
         power_on    <= 1'b0;
         tx_word     <= '0;
         tx_valid    <= 1'b0;
         test_active <= 1'b0;
      end
      else
      begin
         mode        <= next_mode;
         power_on    <= next_power_on;
         tx_word     <= next_tx_word;
         tx_valid    <= next_tx_valid;
         test_active <= (next_mode == link_bist_pkg::MODE_TEST);
      end
   end

   // back channel crc error counters
   always_comb
   begin
      next_crc_func = crc_func;
      next_crc_test = crc_test;
      if (enter)
      begin
         next_crc_func = '0;
         next_crc_test = '0;
      end
      else if (mode == link_bist_pkg::MODE_TEST)
      begin
         if (clr_test_wr)
            next_crc_test = crc_hit ? CNT_W'(link_bist_pkg::CNT_ONE) : '0;
         else if (crc_hit)
            next_crc_test = bump(crc_test);
      end
      else
      begin
         if (clr_test_wr)
            next_crc_test = '0;
         if (crc_hit)
            next_crc_func = bump(crc_func);
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         crc_func <= '0;
         crc_test <= '0;
      end
      else
      begin
         crc_func <= next_crc_func;
         crc_test <= next_crc_test;
      end
   end

   // control, interrupt registers and read port
   always_comb
   begin
      events = '0;
      events[link_bist_pkg::EV_ENTER] = enter;
      events[link_bist_pkg::EV_EXIT]  = leave;
      events[link_bist_pkg::EV_CRC]   = crc_hit;
      next_ctrl     = ctrl;
      next_int_mask = int_mask;
      next_int_stat = int_stat;
      if (wr_hit(addr, link_bist_pkg::ADDR_CTRL))
      begin
         next_ctrl = wr_data;
         next_ctrl[link_bist_pkg::CTRL_CLR_TEST] = 1'b0;
      end
      if (wr_hit(addr, link_bist_pkg::ADDR_INT_MASK))
         next_int_mask = wr_data[link_bist_pkg::EV_W-1:0];
      if (wr_hit(addr, link_bist_pkg::ADDR_INT_STAT))
         next_int_stat = int_stat & ~wr_data[link_bist_pkg::EV_W-1:0];
      next_int_stat = next_int_stat | events; // set wins over clear
      next_irq      = |(next_int_stat & next_int_mask);
      next_rd_data  = '0;
      if (rd_stb)
      begin
         unique case (addr)
            link_bist_pkg::ADDR_CTRL:     next_rd_data = ctrl;
            link_bist_pkg::ADDR_CRC_FUNC: next_rd_data = 32'(crc_func);
            link_bist_pkg::ADDR_CRC_TEST: next_rd_data = 32'(crc_test);
            link_bist_pkg::ADDR_STATUS:
            begin
               next_rd_data[link_bist_pkg::STAT_LINK] = back_chan.link_detect;
               next_rd_data[link_bist_pkg::STAT_TEST] = (mode == link_bist_pkg::MODE_TEST);
               next_rd_data[link_bist_pkg::STAT_OSC]  = back_chan.clk_sel_osc;
            end
            link_bist_pkg::ADDR_INT_STAT: next_rd_data = 32'(int_stat);
            link_bist_pkg::ADDR_INT_MASK: next_rd_data = 32'(int_mask);
            default:                      next_rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctrl     <= link_bist_pkg::CTRL_RESET;
         int_mask <= '0;
         int_stat <= '0;
         irq      <= 1'b0;
         rd_data  <= '0;
      end
      else
      begin
         ctrl     <= next_ctrl;
         int_mask <= next_int_mask;
         int_stat <= next_int_stat;
         irq      <= next_irq;
         rd_data  <= next_rd_data;
      end
   end

   // checks on the test behaviour
   sequence s_exit;
      mode == link_bist_pkg::MODE_TEST ##1 mode == link_bist_pkg::MODE_NORMAL;
   endsequence

   property p_wake;
      @(posedge mclk) disable iff (rst)
      back_chan.test_enable |=> power_on && test_active;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on test enable");

   property p_zeros;
      @(posedge mclk) disable iff (rst)
      (mode == link_bist_pkg::MODE_TEST) && word_tick |=> tx_valid && (tx_word == '0);
   endproperty
   a_zeros: assert property (p_zeros) else $error("test word not all zeros");

   property p_clksel;
      @(posedge mclk) disable iff (rst)
      (mode == link_bist_pkg::MODE_TEST) && back_chan.clk_sel_osc && !osc_tick
         |=> !tx_valid;
   endproperty
   a_clksel: assert property (p_clksel) else $error("word sent off oscillator tick");

   property p_link_gate;
      @(posedge mclk) disable iff (rst)
      !back_chan.link_detect && !enter |=> $stable(crc_func) && crc_test <= $past(crc_test);
   endproperty
   a_link_gate: assert property (p_link_gate) else $error("crc counted without link");

   property p_entry_clear;
      @(posedge mclk) disable iff (rst)
      enter |=> crc_func == '0 && crc_test == '0;
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("counts not cleared");

   property p_test_count;
      @(posedge mclk) disable iff (rst)
      (mode == link_bist_pkg::MODE_TEST) && back_chan.test_enable && crc_hit && !clr_test_wr
         && crc_test != CNT_W'(link_bist_pkg::CNT_MAX)
         |=> crc_test == $past(crc_test) + CNT_W'(1) && $stable(crc_func);
   endproperty
   a_test_count: assert property (p_test_count) else $error("test crc not counted");

   property p_test_hold;
      @(posedge mclk) disable iff (rst)
      (mode == link_bist_pkg::MODE_NORMAL) && !enter && !clr_test_wr |=> $stable(crc_test);
   endproperty
   a_test_hold: assert property (p_test_hold) else $error("test crc lost");

   property p_normal;
      @(posedge mclk) disable iff (rst)
      !back_chan.test_enable |=> !test_active ##0 mode == link_bist_pkg::MODE_NORMAL;
   endproperty
   a_normal: assert property (p_normal) else $error("no return to normal");

   property p_resume;
      @(posedge mclk) disable iff (rst)
      s_exit ##0 pix_en |=> tx_valid && tx_word == $past(video_in);
   endproperty
   a_resume: assert property (p_resume) else $error("video not resumed");

endmodule
`default_nettype wire

// ### rtl/link_bist_pkg.sv
`default_nettype none
package link_bist_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_CRC_FUNC = 8'h04;
   localparam logic [7:0] ADDR_CRC_TEST = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_INT_STAT = 8'h10;
   localparam logic [7:0] ADDR_INT_MASK = 8'h14;

   // control register fields
   localparam int CTRL_SLEEP     = 0;
   localparam int CTRL_CLR_TEST  = 1;

   // status register fields
   localparam int STAT_LINK      = 0;
   localparam int STAT_TEST      = 1;
   localparam int STAT_OSC       = 2;

   // interrupt event bits
   localparam int EV_ENTER       = 0;
   localparam int EV_EXIT        = 1;
   localparam int EV_CRC         = 2;
   localparam int EV_W           = 3;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [7:0]  CNT_MAX    = 8'hFF;
   localparam logic [7:0]  CNT_ONE    = 8'h01;

   // oscillator and system clock rates
   localparam int OSC_FREQ_KHZ  = 33000;
   localparam int MCLK_FREQ_KHZ = 125000;

   typedef enum logic {MODE_NORMAL, MODE_TEST} mode_e;

   // one parallel video word
   typedef struct packed {
      logic [23:0] rgb;
      logic        hsync;
      logic        vsync;
      logic        de;
   } video_s;

   // back channel indications from the frame decoder
   typedef struct packed {
      logic test_enable;
      logic clk_sel_osc;
      logic link_detect;
      logic frame_done;
      logic crc_error;
   } back_chan_s;

endpackage
`default_nettype wire

// ### test/far_end_model.sv
`timescale 1ns/10ps
`default_nettype none
module far_end_model (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  test_enable_pin,
   input  wire logic                  test_clock_select_pin,
   input  wire logic                  lock,
   input  wire logic                  crc_bad,
   input  wire link_bist_pkg::video_s tx_word,
   input  wire logic                  tx_valid,
   output link_bist_pkg::back_chan_s  back_chan,
   output logic                       result_pin,
   output logic [7:0]                 word_errs
);
   logic [1:0] armed;

   // back channel fields sent to the serializer
   assign back_chan = '{test_enable_pin, test_clock_select_pin, lock, 1'b0, crc_bad};

   // zero pattern check, result level held after the run
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         armed <= 2'h0;
         result_pin <= 1'b0;
         word_errs <= 8'h00;
      end
      else
      begin
         armed <= {armed[0], test_enable_pin & lock};
         if (armed == 2'h1)
            result_pin <= 1'b1;
         if (armed == 2'h3 && tx_valid && tx_word !== '0)
         begin
            result_pin <= 1'b0;
            word_errs <= word_errs + 8'h01;
         end
      end
endmodule
`default_nettype wire

// ### test/test_serial_link_bist.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_link_bist;
   logic                      mclk = 1'b0;
   logic                      rst = 1'b1;
   logic                      pix_en = 1'b0;
   link_bist_pkg::video_s     video_in = '0;
   link_bist_pkg::back_chan_s back_chan;
   link_bist_pkg::video_s     tx_word;
   logic [7:0]                addr = 8'h00;
   logic [31:0]               wr_data = 32'h0;
   logic [31:0]               rd_data;
   logic                      wr_stb = 1'b0;
   logic                      rd_stb = 1'b0;
   logic                      tx_valid;
   logic                      power_on;
   logic                      test_active;
   logic                      irq;
   logic                      ten = 1'b0;
   logic                      tsel = 1'b0;
   logic                      lock = 1'b0;
   logic                      crc_bad = 1'b0;
   logic                      rnd_on = 1'b1;
   logic                      slp = 1'b0;
   logic                      result_pin;
   logic [7:0]                word_errs;
   int                        seed = 84;
   int                        fails = 0;
   int                        n_checks = 0;
   int                        cyc = 0;
   int                        i;
   int                        n;
   int                        c;

   serial_link_bist #(
      .CNT_W(8)
   ) serial_link_bist_i (
      .mclk        (mclk),
      .rst         (rst),
      .pix_en      (pix_en),
      .video_in    (video_in),
      .back_chan   (back_chan),
      .addr        (addr),
      .wr_data     (wr_data),
      .wr_stb      (wr_stb),
      .rd_stb      (rd_stb),
      .rd_data     (rd_data),
      .tx_word     (tx_word),
      .tx_valid    (tx_valid),
      .power_on    (power_on),
      .test_active (test_active),
      .irq         (irq)
   );

   far_end_model far_end_model_i (
      .mclk                  (mclk),
      .rst                   (rst),
      .test_enable_pin       (ten),
      .test_clock_select_pin (tsel),
      .lock                  (lock),
      .crc_bad               (crc_bad),
      .tx_word               (tx_word),
      .tx_valid              (tx_valid),
      .back_chan             (back_chan),
      .result_pin            (result_pin),
      .word_errs             (word_errs)
   );

   // clock
   always #4 mclk = ~mclk;

   // random pixel ticks and words
   always @(posedge mclk)
   begin
      pix_en <= rnd_on & 1'($random(seed));
      video_in <= 27'($random(seed));
   end

   // hang limit
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fails++;
         give_verdict;
      end
   end

   task automatic give_verdict;
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      if (a == link_bist_pkg::ADDR_CTRL)
         slp = d[link_bist_pkg::CTRL_SLEEP];
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 chk(rd_data, e);
   endtask

   task automatic crc(input int k);
      repeat (k)
      begin
         @(posedge mclk);
         crc_bad <= 1'b1;
         @(posedge mclk);
         crc_bad <= 1'b0;
      end
   endtask

   // counts ticks; zeros in test, pass-through otherwise
   task automatic run(input int k, output int t);
      logic                  pe;
      link_bist_pkg::video_s v;
      t = 0;
      pe = 1'b0;
      v = '0;
      repeat (k)
      begin
         @(posedge mclk);
         #1 t += int'(tx_valid);
         if (test_active === 1'b1 && tx_valid === 1'b1)
            chk(32'(tx_word), 32'h0);
         if (test_active === 1'b0 && pe)
            chk(32'({tx_valid, tx_word}), 32'({1'b1, v}));
         pe = pix_en & ~test_active;
         v = video_in;
      end
   endtask

   task automatic enter(input logic e);
      @(posedge mclk);
      ten <= e;
      @(posedge mclk);
      #1 chk(32'({power_on, test_active}), 32'({e | ~slp, e}));
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1 chk(32'({power_on, irq}), 32'h2);
      for (i = 0; i < 7; i++)
         rc(8'(i * 4), 32'h0);
      crc(3);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'h0);
      lock <= 1'b1;
      n = 2 + ($random(seed) & 7);
      crc(n);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'(n));
      rc(link_bist_pkg::ADDR_STATUS, 32'h1);
      wr(link_bist_pkg::ADDR_CTRL, 32'h1);
      for (i = 0; i < 8 && power_on !== 1'b0; i++)
         @(posedge mclk);
      #1 chk(32'(power_on), 32'h0);
      enter(1'b1);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'h0);
      rc(link_bist_pkg::ADDR_STATUS, 32'h3);
      run(100, c);
      tsel <= 1'b1;
      rnd_on <= 1'b0;
      repeat (3) @(posedge mclk);
      rc(link_bist_pkg::ADDR_STATUS, 32'h7);
      run(125, c);
      chk(32'(c), 32'h21);
      tsel <= 1'b0;
      repeat (3) @(posedge mclk);
      run(20, c);
      chk(32'(c), 32'h0);
      n = 1 + ($random(seed) & 15);
      crc(n);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'(n));
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'h0);
      enter(1'b0);
      rnd_on <= 1'b1;
      run(60, c);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'(n));
      crc(2);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'h2);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'(n));
      enter(1'b1);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'h0);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'h0);
      crc(1);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'h1);
      wr(link_bist_pkg::ADDR_CTRL, 32'h3);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'h0);
      crc(1);
      enter(1'b0);
      wr(link_bist_pkg::ADDR_CTRL, 32'h2);
      rc(link_bist_pkg::ADDR_CRC_TEST, 32'h0);
      rc(link_bist_pkg::ADDR_INT_STAT, 32'h7);
      chk(32'(irq), 32'h0);
      wr(link_bist_pkg::ADDR_INT_MASK, 32'h4);
      rc(link_bist_pkg::ADDR_INT_MASK, 32'h4);
      chk(32'(irq), 32'h1);
      wr(link_bist_pkg::ADDR_INT_STAT, 32'h4);
      rc(link_bist_pkg::ADDR_INT_STAT, 32'h3);
      chk(32'(irq), 32'h0);
      crc(300);
      rc(link_bist_pkg::ADDR_CRC_FUNC, 32'hFF);
      chk(32'({result_pin, word_errs}), 32'h100);
      give_verdict;
   end
endmodule
`default_nettype wire
